// File: rtl/cdcr_pkg.sv
// Shared constants for the codec datapath control register bank.
package cdcr_pkg;
    // Register addresses in the control-bus page.
    localparam logic [7:0] CDCR_ADDR_PROG = 8'h3d;
    localparam logic [7:0] CDCR_ADDR_COND = 8'h3e;
    localparam logic [7:0] CDCR_ADDR_ROUTE = 8'h3f;
    localparam logic [7:0] CDCR_ADDR_MUTE = 8'h40;
    // Reset values.
    localparam logic [7:0] CDCR_RST_PROG = 8'h04;
    localparam logic [7:0] CDCR_RST_COND = 8'h00;
    localparam logic [7:0] CDCR_RST_ROUTE = 8'h14;
    localparam logic [7:0] CDCR_RST_MUTE = 8'h0c;
    // Field positions.
    localparam int CDCR_PROG_LSB = 0;
    localparam int CDCR_REC_COND_A = 6;
    localparam int CDCR_REC_COND_B = 5;
    localparam int CDCR_REC_HOLD = 4;
    localparam int CDCR_PLAY_COND_A = 2;
    localparam int CDCR_PLAY_COND_B = 1;
    localparam int CDCR_PLAY_HOLD = 0;
    localparam int CDCR_PWR_LEFT = 7;
    localparam int CDCR_PWR_RIGHT = 6;
    localparam int CDCR_SRC_LEFT_LSB = 4;
    localparam int CDCR_SRC_RIGHT_LSB = 2;
    localparam int CDCR_STEP_LSB = 0;
    localparam int CDCR_MUTE_LEFT = 3;
    localparam int CDCR_MUTE_RIGHT = 2;
    localparam int CDCR_COUPLE_LSB = 0;
    // Writable masks: reserved bits of the condition register read zero.
    localparam logic [7:0] CDCR_MASK_COND = 8'h77;
    // Sample width.
    localparam int CDCR_SAMPLE_W = 24;
    // Source select codes.
    localparam logic [1:0] CDCR_SRC_OFF = 2'h0;
    localparam logic [1:0] CDCR_SRC_SAME = 2'h1;
    localparam logic [1:0] CDCR_SRC_SWAP = 2'h2;
    localparam logic [1:0] CDCR_SRC_AVG = 2'h3;
    // Soft-step codes.
    typedef enum logic [1:0] {
        CDCR_STEP_ONE = 2'b00,
        CDCR_STEP_TWO = 2'b01,
        CDCR_STEP_OFF = 2'b10,
        CDCR_STEP_BAD = 2'b11
    } cdcr_step_e;
endpackage

// File: rtl/cdcr_source_mux.sv
// One playback channel source selector with averaging.
`timescale 1ns/10ps
module cdcr_source_mux
    import cdcr_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic nrst,
    // Selection and samples.
    input wire logic [1:0] sel,
    input wire logic [CDCR_SAMPLE_W-1:0] own_sample,
    input wire logic [CDCR_SAMPLE_W-1:0] other_sample,
    // Selected sample.
    output logic [CDCR_SAMPLE_W-1:0] out_sample
);
    logic [CDCR_SAMPLE_W:0] sum;
    logic [CDCR_SAMPLE_W-1:0] avg;
    logic [CDCR_SAMPLE_W-1:0] pick;

    // Sign-extended sum, then arithmetic halving keeps the range.
    assign sum = {own_sample[CDCR_SAMPLE_W-1], own_sample}
        + {other_sample[CDCR_SAMPLE_W-1], other_sample};
    assign avg = sum[CDCR_SAMPLE_W:1];
    // Selection; code off passes silence.
    assign pick = (sel == CDCR_SRC_SAME) ? own_sample :
        (sel == CDCR_SRC_SWAP) ? other_sample :
        (sel == CDCR_SRC_AVG) ? avg : '0;

    // Registered output so data leaves from flip-flops.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            out_sample <= '0;
        end else begin
            out_sample <= pick;
        end
    end
endmodule

// File: rtl/cdcr_instr_counter.sv
// Instruction counter of one processing engine with frame restart.
`timescale 1ns/10ps
module cdcr_instr_counter
    import cdcr_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic nrst,
    // Engine control.
    input wire logic step,
    input wire logic frame_start,
    input wire logic hold_across_frames,
    // Counter value.
    output logic [9:0] count
);
    logic [9:0] count_next;

    // Frame start clears unless the hold bit keeps it running.
    assign count_next = (frame_start && !hold_across_frames) ? 10'h000 :
        step ? count + 10'h001 : count;

    // Counter register.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count <= 10'h000;
        end else begin
            count <= count_next;
        end
    end
endmodule

// File: rtl/cdcr_regs.sv
// Codec datapath control register bank with playback routing and muting.
`timescale 1ns/10ps
module cdcr_regs
    import cdcr_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic nrst,
    // Register port from the control-bus slave.
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // Compressor enables from its own control register.
    input wire logic compressor_en_left,
    input wire logic compressor_en_right,
    // Programmed channel volumes.
    input wire logic [7:0] vol_left_prog,
    input wire logic [7:0] vol_right_prog,
    // Engine timing.
    input wire logic frame_start,
    input wire logic rec_step,
    input wire logic play_step,
    // Playback samples in.
    input wire logic [CDCR_SAMPLE_W-1:0] left_in,
    input wire logic [CDCR_SAMPLE_W-1:0] right_in,
    // Record engine controls.
    output logic [4:0] record_program,
    output logic record_program_valid,
    output logic rec_cond_a,
    output logic rec_cond_b,
    output logic [9:0] rec_count,
    // Playback engine controls.
    output logic play_cond_a,
    output logic play_cond_b,
    output logic [9:0] play_count,
    // Playback channel controls.
    output logic pwr_left,
    output logic pwr_right,
    output logic mute_left,
    output logic mute_right,
    output logic soft_step_en,
    output logic soft_step_two,
    output logic [7:0] vol_left_eff,
    output logic [7:0] vol_right_eff,
    output logic [CDCR_SAMPLE_W-1:0] left_out,
    output logic [CDCR_SAMPLE_W-1:0] right_out
);
    ////////////////////////////////////////////////////////////////////////
    // Register storage.
    logic [7:0] prog_reg;
    logic [7:0] prog_next;
    logic [7:0] cond_reg;
    logic [7:0] cond_next;
    logic [7:0] route_reg;
    logic [7:0] route_next;
    logic [7:0] mute_reg;
    logic [7:0] mute_next;
    logic [7:0] vol_left_reg;
    logic [7:0] vol_right_reg;
    logic [7:0] vol_left_next;
    logic [7:0] vol_right_next;
    logic hit_prog;
    logic hit_cond;
    logic hit_route;
    logic hit_mute;
    logic [1:0] couple;
    logic [1:0] step_code;
    logic compressor_any;

    // Checks a program code against the nine implemented variants.
    function automatic logic prog_is_valid(input logic [4:0] code);
        prog_is_valid = (code >= 5'h04 && code <= 5'h06) ||
            (code >= 5'h0a && code <= 5'h0c) ||
            (code >= 5'h10 && code <= 5'h12);
    endfunction

    // Address decode.
    assign hit_prog = (reg_addr == CDCR_ADDR_PROG);
    assign hit_cond = (reg_addr == CDCR_ADDR_COND);
    assign hit_route = (reg_addr == CDCR_ADDR_ROUTE);
    assign hit_mute = (reg_addr == CDCR_ADDR_MUTE);
    assign reg_hit = hit_prog | hit_cond | hit_route | hit_mute;

    // Next values. Reserved bits of the program and mute registers are stored as written since the host
    // keeps them at their defaults.
    assign prog_next = (reg_wr && hit_prog) ? reg_wdata : prog_reg;
    assign cond_next = (reg_wr && hit_cond) ?
        (reg_wdata & CDCR_MASK_COND) : cond_reg;
    assign route_next = (reg_wr && hit_route) ? reg_wdata : route_reg;
    assign mute_next = (reg_wr && hit_mute) ? reg_wdata : mute_reg;

    // Register file; unmapped addresses simply ignore writes.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prog_reg <= CDCR_RST_PROG;
            cond_reg <= CDCR_RST_COND;
            route_reg <= CDCR_RST_ROUTE;
            mute_reg <= CDCR_RST_MUTE;
        end else begin
            prog_reg <= prog_next;
            cond_reg <= cond_next;
            route_reg <= route_next;
            mute_reg <= mute_next;
        end
    end

    // Read-back multiplexer; unmapped addresses read zero.
    assign reg_rdata = hit_prog ? prog_reg :
        hit_cond ? cond_reg :
        hit_route ? route_reg :
        hit_mute ? mute_reg : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Record and playback engine controls.
    // A reserved code is flagged so the engine can idle rather than run
    // an unknown program.
    assign record_program = prog_reg[CDCR_PROG_LSB +: 5];
    assign record_program_valid = prog_is_valid(record_program);
    assign rec_cond_a = cond_reg[CDCR_REC_COND_A];
    assign rec_cond_b = cond_reg[CDCR_REC_COND_B];
    assign play_cond_a = cond_reg[CDCR_PLAY_COND_A];
    assign play_cond_b = cond_reg[CDCR_PLAY_COND_B];

    // Record engine counter.
    cdcr_instr_counter u_rec_count (
        .clock(clock),
        .nrst(nrst),
        .step(rec_step),
        .frame_start(frame_start),
        .hold_across_frames(cond_reg[CDCR_REC_HOLD]),
        .count(rec_count)
    );

    // Playback engine counter.
    cdcr_instr_counter u_play_count (
        .clock(clock),
        .nrst(nrst),
        .step(play_step),
        .frame_start(frame_start),
        .hold_across_frames(cond_reg[CDCR_PLAY_HOLD]),
        .count(play_count)
    );

    ////////////////////////////////////////////////////////////////////////
    // Playback channel power, mute and soft-step.
    assign pwr_left = route_reg[CDCR_PWR_LEFT];
    assign pwr_right = route_reg[CDCR_PWR_RIGHT];
    assign mute_left = mute_reg[CDCR_MUTE_LEFT];
    assign mute_right = mute_reg[CDCR_MUTE_RIGHT];

    // Forbidden code 11 is treated as stepping off, the safest reading.
    assign step_code = route_reg[CDCR_STEP_LSB +: 2];
    assign soft_step_en = (step_code == CDCR_STEP_ONE) ||
        (step_code == CDCR_STEP_TWO);
    assign soft_step_two = (step_code == CDCR_STEP_TWO);

    ////////////////////////////////////////////////////////////////////////
    // Volume coupling; the compressor on either channel overrides it.
    assign couple = mute_reg[CDCR_COUPLE_LSB +: 2];
    assign compressor_any = compressor_en_left | compressor_en_right;
    assign vol_left_next = (!compressor_any && couple == 2'b01) ?
        vol_right_prog : vol_left_prog;
    assign vol_right_next = (!compressor_any && couple == 2'b10) ?
        vol_left_prog : vol_right_prog;

    // Effective volumes are registered to keep data outputs clean.
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            vol_left_reg <= 8'h00;
            vol_right_reg <= 8'h00;
        end else begin
            vol_left_reg <= vol_left_next;
            vol_right_reg <= vol_right_next;
        end
    end
    assign vol_left_eff = vol_left_reg;
    assign vol_right_eff = vol_right_reg;

    ////////////////////////////////////////////////////////////////////////
    // Source routing for each channel; own and other swap for the right.
    cdcr_source_mux u_left_mux (
        .clock(clock),
        .nrst(nrst),
        .sel(route_reg[CDCR_SRC_LEFT_LSB +: 2]),
        .own_sample(left_in),
        .other_sample(right_in),
        .out_sample(left_out)
    );

    cdcr_source_mux u_right_mux (
        .clock(clock),
        .nrst(nrst),
        .sel(route_reg[CDCR_SRC_RIGHT_LSB +: 2]),
        .own_sample(right_in),
        .other_sample(left_in),
        .out_sample(right_out)
    );
endmodule

// File: tb/cdcr_regs_monitor.sv
// Concurrent checks on the ports of the control register bank.
`timescale 1ns/10ps
module cdcr_regs_monitor
    import cdcr_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic nrst,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_hit,
    // Engine and channel signals.
    input wire logic frame_start,
    input wire logic [CDCR_SAMPLE_W-1:0] left_in,
    input wire logic [4:0] record_program,
    input wire logic record_program_valid,
    input wire logic [9:0] rec_count,
    input wire logic pwr_left,
    input wire logic mute_left,
    input wire logic soft_step_en,
    input wire logic soft_step_two,
    input wire logic [CDCR_SAMPLE_W-1:0] left_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////
    // Register writes, the first step of the write checks.
    sequence wr_prog; reg_wr && reg_addr == CDCR_ADDR_PROG; endsequence
    sequence wr_route; reg_wr && reg_addr == CDCR_ADDR_ROUTE; endsequence
    sequence wr_mute; reg_wr && reg_addr == CDCR_ADDR_MUTE; endsequence
    // Reading a register shows its stored value, so decodes key on it.
    a_prog_write: assert property (wr_prog |=>
        record_program == $past(reg_wdata[4:0])) else $error("prog");
    a_prog_valid: assert property (record_program_valid ==
        (record_program inside {5'h04, 5'h05, 5'h06, 5'h0a, 5'h0b,
        5'h0c, 5'h10, 5'h11, 5'h12})) else $error("valid flag");
    a_pwr_write: assert property (wr_route |=>
        pwr_left == $past(reg_wdata[7])) else $error("power");
    a_mute_write: assert property (wr_mute |=>
        mute_left == $past(reg_wdata[3])) else $error("mute");
    a_step_decode: assert property (reg_addr == CDCR_ADDR_ROUTE |->
        soft_step_en == (reg_rdata[1:0] inside {2'h0, 2'h1}) &&
        soft_step_two == (reg_rdata[1:0] == 2'h1)) else $error("step");
    a_count_clear: assert property (frame_start &&
        reg_addr == CDCR_ADDR_COND && !reg_rdata[4] |=>
        rec_count == 10'h000) else $error("count clear");
    a_left_same: assert property (reg_addr == CDCR_ADDR_ROUTE &&
        reg_rdata[5:4] == CDCR_SRC_SAME |=> left_out == $past(left_in))
        else $error("left source");
    a_hit_decode: assert property (reg_hit ==
        (reg_addr inside {[8'h3d:8'h40]}) && (reg_hit || reg_rdata == 8'h00))
        else $error("decode");
endmodule
////////////////////////////////////////////////////////////////////////
bind cdcr_regs cdcr_regs_monitor cdcr_regs_monitor_i (.clock, .nrst,
    .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .reg_hit, .frame_start,
    .left_in, .record_program, .record_program_valid, .rec_count,
    .pwr_left, .mute_left, .soft_step_en, .soft_step_two, .left_out);

// File: tb/cdcr_host_model.sv
// Host model that turns bench requests into register port writes.
`timescale 1ns/10ps
module cdcr_host_model (
    // Clock.
    input wire logic clock,
    // Requests from the bench.
    input wire logic req_wr,
    input wire logic [7:0] req_addr,
    input wire logic [7:0] req_data,
    // Register port.
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata
);
    logic [7:0] clean;
    logic [7:0] last_data;
    ////////////////////////////////////////////////////////////////////
    // Reserved bits of the program and mute registers go out as zero and step code 11 is never sent.
    assign clean = (req_addr == 8'h3d) ? {3'h0, req_data[4:0]} :
        (req_addr == 8'h40) ? {4'h0, req_data[3:0]} :
        (req_addr == 8'h3f && &req_data[1:0]) ? (req_data ^ 8'h01) :
        req_data;
    // Idle data toggles so a stale value can never look like a write.
    assign reg_addr = req_addr;
    assign reg_wr = req_wr;
    assign reg_wdata = req_wr ? clean : ~last_data;
    // Remember the last value put on the data lines.
    always @(posedge clock) begin
        last_data <= reg_wdata;
    end
endmodule

// File: tb/cdcr_regs_test.sv
// Self-checking bench for the control register bank.
`timescale 1ns/10ps
module cdcr_regs_test
    import cdcr_pkg::*;
;
    logic clock = 0, nrst = 0, req_wr = 0;
    logic compressor_en_left = 0, compressor_en_right = 0;
    logic frame_start = 0, rec_step = 0, play_step = 0;
    logic [7:0] req_addr = 8'h00, req_data = 8'h00;
    logic [7:0] vol_left_prog = 8'h11, vol_right_prog = 8'h22;
    logic [23:0] left_in = 24'hfffffa, right_in = 24'h000003;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, vol_left_eff, vol_right_eff;
    logic reg_wr, reg_hit, record_program_valid, rec_cond_a, rec_cond_b;
    logic play_cond_a, play_cond_b, pwr_left, pwr_right, mute_left;
    logic mute_right, soft_step_en, soft_step_two;
    logic [4:0] record_program;
    logic [9:0] rec_count, play_count;
    logic [23:0] left_out, right_out;
    int miscompares = 0, total_checks = 0;
    cdcr_host_model cdcr_host_model_i (.clock, .req_wr, .req_addr,
        .req_data, .reg_addr, .reg_wr, .reg_wdata);
    cdcr_regs cdcr_regs_i (.clock, .nrst, .reg_addr, .reg_wr, .reg_wdata,
        .reg_rdata, .reg_hit, .compressor_en_left, .compressor_en_right,
        .vol_left_prog,
        .vol_right_prog, .frame_start, .rec_step, .play_step, .left_in,
        .right_in, .record_program, .record_program_valid, .rec_cond_a,
        .rec_cond_b, .rec_count, .play_cond_a, .play_cond_b, .play_count,
        .pwr_left, .pwr_right, .mute_left, .mute_right, .soft_step_en,
        .soft_step_two, .vol_left_eff, .vol_right_eff, .left_out, .right_out);
    ////////////////////////////////////////////////////////////////////
    // Free-running 125 MHz clock.
    always #4 clock = ~clock;
    // Compare one value and count the result.
    task chk(input string what, input logic [23:0] exp,
        input logic [23:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask
    // One write cycle; the address is left in place for later decodes.
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        req_addr = a;
        req_data = d;
        req_wr = 1'b1;
        @(negedge clock);
        req_wr = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clock);
        req_addr = a;
        #1;
        chk("rdata", {16'h0, exp}, {16'h0, reg_rdata});
    endtask
    // Bench samples give an average of (-6 + 3) / 2 floored, that is -2.
    function logic [23:0] pick(input int s, input logic [23:0] own, oth);
        return (s == 0) ? 24'h0 : (s == 1) ? own : (s == 2) ? oth : 24'hfffffe;
    endfunction
    ////////////////////////////////////////////////////////////////////
    task t_reset;
        rd(8'h3d, 8'h04);
        rd(8'h3e, 8'h00);
        rd(8'h3f, 8'h14);
        rd(8'h40, 8'h0c);
        rd(8'h41, 8'h00);
        chk("power", 24'h0, {pwr_left, pwr_right});
        chk("mute", 24'h3, {mute_left, mute_right});
        chk("step", 24'h2, {soft_step_en, soft_step_two});
        chk("counts", 24'h0, {rec_count, play_count});
        chk("program", 24'h04, record_program);
        $display("reset values done");
    endtask
    task t_prog;
        logic [4:0] codes [9] = '{4, 5, 6, 10, 11, 12, 16, 17, 18};
        foreach (codes[i]) begin
            wr(CDCR_ADDR_PROG, {3'h0, codes[i]});
            chk("program", codes[i], record_program);
            chk("valid", 24'h1, record_program_valid);
        end
        $display("program select done");
    endtask
    task t_cond;
        wr(CDCR_ADDR_COND, 8'hff);
        rd(CDCR_ADDR_COND, 8'h77);
        chk("cond", 24'hf,
            {rec_cond_a, rec_cond_b, play_cond_a, play_cond_b});
        $display("condition bits done");
    endtask
    // Run both counters, then a frame start with hold off and on.
    task t_count;
        for (int h = 0; h < 2; h++) begin
            wr(CDCR_ADDR_COND, h ? 8'h11 : 8'h00);
            rec_step = 1'b1;
            play_step = 1'b1;
            repeat (3) @(negedge clock);
            rec_step = 1'b0;
            play_step = 1'b0;
            frame_start = 1'b1;
            @(negedge clock);
            frame_start = 1'b0;
            chk("rec count", h ? 24'h3 : 24'h0, rec_count);
            chk("play count", h ? 24'h3 : 24'h0, play_count);
        end
        $display("frame restart done");
    endtask
    task t_route;
        logic [1:0] st;
        for (int s = 0; s < 4; s++) begin
            st = (s == 3) ? 2'h0 : s[1:0];
            wr(CDCR_ADDR_ROUTE, {2'h3, s[1:0], s[1:0], st});
            @(negedge clock);
            chk("left out", pick(s, left_in, right_in), left_out);
            chk("right out", pick(s, right_in, left_in), right_out);
            chk("power", 24'h3, {pwr_left, pwr_right});
            chk("step", {st != 2'h2, st == 2'h1},
                {soft_step_en, soft_step_two});
        end
        $display("routing done");
    endtask
    task t_vol;
        for (int c = 0; c < 4; c++) begin
            wr(CDCR_ADDR_MUTE, {4'h0, c[0], c[1], c[1:0]});
            @(negedge clock);
            chk("mute", {c[0], c[1]}, {mute_left, mute_right});
            chk("vol left", (c == 1) ? 8'h22 : 8'h11, vol_left_eff);
            chk("vol right", (c == 2) ? 8'h11 : 8'h22, vol_right_eff);
        end
        compressor_en_right = 1'b1;
        wr(CDCR_ADDR_MUTE, 8'h01);
        @(negedge clock);
        chk("vol left", 24'h11, vol_left_eff);
        compressor_en_right = 1'b0;
        compressor_en_left = 1'b1;
        wr(CDCR_ADDR_MUTE, 8'h02);
        @(negedge clock);
        chk("vol right", 24'h22, vol_right_eff);
        $display("mute and coupling done");
    endtask
    ////////////////////////////////////////////////////////////////////
    task conclude;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // The tests need well under a thousand cycles.
    initial begin
        #100000;
        miscompares++;
        conclude();
    end
    // Main sequence.
    initial begin
        repeat (5) @(negedge clock);
        nrst = 1'b1;
        t_reset();
        t_prog();
        t_cond();
        t_count();
        t_route();
        t_vol();
        // A reset in mid-run must bring every register back to default.
        @(negedge clock);
        nrst = 1'b0;
        @(negedge clock);
        nrst = 1'b1;
        t_reset();
        conclude();
    end
endmodule
